//--- mode_six_pkg.sv
// Behaviour
// [R1] Controller writes zero to bits 21, 17
// [R2] Device routes writes by select bits 20:18
// [R3] Bits 12:10 encode spacing 4 to 8
// [R4] Controller picks spacing from data rate
// [R5] Device accepts spacing down to four cycles
// [R6] Controller writes zero equalisation field
// [R7] Bit 7 switches reference training on
// [R8] Bit 6 selects reference training range
// [R9] Bits 5:0 hold reference level code
// [R10] Ranges span 60-92 and 45-77 percent
// [R11] Fifty levels, about 0.65 percent steps
// [R12] Training enable set when changing bits 6:0
// [R13] Strobes and write enable low on write
// [R14] Word bits ride bank and address pins
// [R15] Controller never writes reserved spacing codes
// [R16] Fields hold until next matching write
package mode_six_pkg;

  // Word layout
  localparam int WORD_W       = 22;
  localparam int RSV_HI_BIT   = 21;
  localparam int SEL_HI       = 20;
  localparam int SEL_LO       = 18;
  localparam int RSV_LO_BIT   = 17;
  localparam int CMD_PIN_HI   = 16;
  localparam int CMD_PIN_LO   = 14;
  localparam int EQ_HI_BIT    = 13;
  localparam int SPACE_HI     = 12;
  localparam int SPACE_LO     = 10;
  localparam int EQ_MID_BIT   = 9;
  localparam int EQ_LO_BIT    = 8;
  localparam int TRAIN_EN_BIT = 7;
  localparam int RANGE_BIT    = 6;
  localparam int LEVEL_HI     = 5;

  // Select codes
  localparam logic [2:0] SEL_SIXTH     = 3'h6;
  localparam logic [2:0] SEL_FORBIDDEN = 3'h7;

  // Spacing codes and cycle counts
  localparam logic [2:0] SPACE_CODE_4   = 3'h0;
  localparam logic [2:0] SPACE_CODE_5   = 3'h1;
  localparam logic [2:0] SPACE_CODE_6   = 3'h2;
  localparam logic [2:0] SPACE_CODE_7   = 3'h3;
  localparam logic [2:0] SPACE_CODE_8   = 3'h4;
  localparam logic [3:0] SPACE_FLOOR    = 4'h4;
  localparam logic [3:0] SPACE_CEIL     = 4'h8;
  localparam logic [3:0] GAP_IDLE       = 4'hf;

  // Data rate limits per spacing code, Mb/s
  localparam int RATE_4_MAX = 1333;
  localparam int RATE_5_MAX = 1866;
  localparam int RATE_6_MAX = 2400;
  localparam int RATE_7_MAX = 2666;
  localparam int RATE_8_MAX = 3200;

  // Timed spacing lower bound
  localparam int CLK_MHZ        = 100;
  localparam int SPACE_TIME_NS  = 5;
  localparam int SPACE_TIME_RAW = (SPACE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SPACE_TIME_CYC = (SPACE_TIME_RAW < 1) ? 4'h1 : 4'(SPACE_TIME_RAW);

  // Equalisation and reference levels, hundredths of a percent of supply
  localparam logic [2:0]  EQ_DEFAULT     = 3'h0;
  localparam logic [5:0]  LEVEL_COUNT    = 6'h32;
  localparam logic [13:0] RANGE1_BASE    = 14'h1770;
  localparam logic [13:0] RANGE2_BASE    = 14'h1194;
  localparam logic [13:0] LEVEL_STEP     = 14'h0041;

  // Reset values
  localparam logic [2:0]  SPACE_RESET    = 3'h0;
  localparam logic [5:0]  LEVEL_RESET    = 6'h00;
  localparam logic [13:0] PCT_RESET      = 14'h1770;

endpackage

//--- mode_link.sv
`timescale 1ns/1ns
// Command and address pins between controller and memory
interface mode_link;
  logic       cs_n;
  logic       act_n;
  logic       ras_n;
  logic       cas_n;
  logic       we_n;
  logic [1:0] bg;
  logic [1:0] ba;
  logic       a17;
  logic [13:0] a;

  modport controller (output cs_n, act_n, ras_n, cas_n, we_n, bg, ba, a17, a);
  modport device     (input  cs_n, act_n, ras_n, cas_n, we_n, bg, ba, a17, a);
endinterface

//--- mode_six_device_end.sv
`timescale 1ns/1ns
module mode_six_device_end
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  mode_link.device         link,
  output logic [6:0]       mode_write_pulse,
  output logic             forbidden_code_pulse,
  output logic             reserved_bit_err,
  output logic             equalisation_err,
  output logic             spacing_code_err,
  output logic             level_code_err,
  output logic             unguarded_change_err,
  output logic [2:0]       data_receiver_equalisation,
  output logic [2:0]       spacing_code,
  output logic [3:0]       spacing_cycles,
  output logic             spacing_violation_pulse,
  output logic             training_enable,
  output logic             training_range,
  output logic [5:0]       training_level,
  output logic [13:0]      level_hundredths
);

  logic              mode_cmd;
  logic              col_cmd;
  logic [21:0]       word;
  logic [2:0]        sel;
  logic              sixth_write;
  logic [2:0]        word_space;
  logic [3:0]        next_spacing;
  logic [13:0]       next_pct;
  logic [3:0]        gap [4];
  // Gap tracking for the column spacing check
  logic              prior_col;
  logic [3:0]        col_distance;

  // Command decode on the rising edge, strobes and write enable all low
  // Activate high keeps the three strobes as command pins, not row address
  assign mode_cmd = !link.cs_n && link.act_n && !link.ras_n && !link.cas_n && !link.we_n;
  assign col_cmd  = !link.cs_n && link.act_n && link.ras_n && !link.cas_n;

  // Word assembled by pin index; command pins carry no word bits
  // Bits 16:14 sit under the strobe pins and always read as zero
  assign word = {link.bg, link.ba, link.a17, 3'h0, link.a}; // [R14]

  // Select field routes the write; code seven reaches no register
  assign sel         = word[mode_six_pkg::SEL_HI:mode_six_pkg::SEL_LO];
  assign sixth_write = mode_cmd && (sel == mode_six_pkg::SEL_SIXTH); // [R2]
  assign word_space  = word[mode_six_pkg::SPACE_HI:mode_six_pkg::SPACE_LO];

  // Spacing in cycles from the stored code, floor four, timed bound respected
  // A timed bound shorter than the floor leaves the floor in charge
  always_comb
  begin
    case (spacing_code)
      mode_six_pkg::SPACE_CODE_4: next_spacing = 4'h4; // [R3]
      mode_six_pkg::SPACE_CODE_5: next_spacing = 4'h5;
      mode_six_pkg::SPACE_CODE_6: next_spacing = 4'h6;
      mode_six_pkg::SPACE_CODE_7: next_spacing = 4'h7;
      mode_six_pkg::SPACE_CODE_8: next_spacing = 4'h8;
      default:                    next_spacing = mode_six_pkg::SPACE_CEIL; // Reserved codes run safest
    endcase
    if (next_spacing < mode_six_pkg::SPACE_TIME_CYC)
    begin
      next_spacing = mode_six_pkg::SPACE_TIME_CYC;
    end
    if (next_spacing < mode_six_pkg::SPACE_FLOOR)
    begin
      next_spacing = mode_six_pkg::SPACE_FLOOR; // [R5]
    end
  end

  // Reference level in hundredths of a percent, base by range plus step per code
  // Codes of fifty and up run past the level table; the error flag reports them
  always_comb
  begin
    next_pct = (training_range ? mode_six_pkg::RANGE2_BASE : mode_six_pkg::RANGE1_BASE)
             + 14'(training_level * mode_six_pkg::LEVEL_STEP); // [R10] [R11]
  end

  // One-cycle write strobe per selected register, forbidden code flagged
  // Writes to the other six registers only pulse; nothing is stored here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_write_pulse     <= 7'h00;
      forbidden_code_pulse <= 1'b0;
    end
    else
    begin
      mode_write_pulse     <= 7'h00;
      forbidden_code_pulse <= mode_cmd && (sel == mode_six_pkg::SEL_FORBIDDEN); // [R2]
      if (mode_cmd && (sel != mode_six_pkg::SEL_FORBIDDEN))
      begin
        mode_write_pulse[sel] <= 1'b1; // [R2]
      end
    end
  end

  // Register fields, held until the next write to this register
  // Reserved content is kept as written; the flags below report it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spacing_code               <= mode_six_pkg::SPACE_RESET;
      data_receiver_equalisation <= mode_six_pkg::EQ_DEFAULT;
      training_enable            <= 1'b0;
      training_range             <= 1'b0;
      training_level             <= mode_six_pkg::LEVEL_RESET;
    end
    else if (sixth_write) // [R16]
    begin
      spacing_code               <= word_space; // [R3]
      data_receiver_equalisation <= {word[mode_six_pkg::EQ_HI_BIT], word[mode_six_pkg::EQ_MID_BIT],
                                     word[mode_six_pkg::EQ_LO_BIT]};
      training_enable            <= word[mode_six_pkg::TRAIN_EN_BIT]; // [R7]
      training_range             <= word[mode_six_pkg::RANGE_BIT]; // [R8]
      training_level             <= word[mode_six_pkg::LEVEL_HI:0]; // [R9]
    end
  end

  // Status of the last write to this register, reserved content flagged
  // Flags are not sticky: each follows the latest write only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reserved_bit_err     <= 1'b0;
      equalisation_err     <= 1'b0;
      spacing_code_err     <= 1'b0;
      level_code_err       <= 1'b0;
      unguarded_change_err <= 1'b0;
    end
    else if (sixth_write)
    begin
      reserved_bit_err     <= word[mode_six_pkg::RSV_HI_BIT] || word[mode_six_pkg::RSV_LO_BIT];
      equalisation_err     <= word[mode_six_pkg::EQ_HI_BIT] || word[mode_six_pkg::EQ_MID_BIT]
                              || word[mode_six_pkg::EQ_LO_BIT];
      spacing_code_err     <= word_space > mode_six_pkg::SPACE_CODE_8; // [R3]
      level_code_err       <= word[mode_six_pkg::LEVEL_HI:0] >= mode_six_pkg::LEVEL_COUNT; // [R11]
      unguarded_change_err <= !word[mode_six_pkg::TRAIN_EN_BIT]
                              && ({word[mode_six_pkg::RANGE_BIT], word[mode_six_pkg::LEVEL_HI:0]}
                                  != {training_range, training_level});
    end
  end

  // Derived spacing and level follow the stored fields one cycle later
  // Registered so that both outputs come straight from flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spacing_cycles   <= mode_six_pkg::SPACE_FLOOR;
      level_hundredths <= mode_six_pkg::PCT_RESET;
    end
    else
    begin
      spacing_cycles   <= next_spacing;
      level_hundredths <= next_pct;
    end
  end

  // Cycles since the last column command, one counter per bank group
  // Counters park at the idle value, so a long quiet spell reads as no prior command
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : group_gap
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          gap[g] <= mode_six_pkg::GAP_IDLE;
        end
        else if (col_cmd && (link.bg == 2'(g)))
        begin
          gap[g] <= 4'h0;
        end
        else if (gap[g] != mode_six_pkg::GAP_IDLE)
        begin
          gap[g] <= gap[g] + 4'h1;
        end
      end
    end
  endgenerate

  // Distance to the previous column command in the addressed group; an idle
  // counter means no earlier command, so the first one in a group never flags
  assign prior_col    = gap[link.bg] != mode_six_pkg::GAP_IDLE;
  assign col_distance = gap[link.bg] + 4'h1;

  // Column command closer than the spacing to the previous one in its group
  // Adjacent commands in one group are one cycle apart
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spacing_violation_pulse <= 1'b0;
    end
    else
    begin
      spacing_violation_pulse <= col_cmd && prior_col && (col_distance < spacing_cycles); // [R5]
    end
  end

endmodule

//--- mode_six_controller_end.sv
`timescale 1ns/1ns
module mode_six_controller_end
#(
  parameter int DATA_RATE = 3200
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  mode_link.controller     link,
  input  wire logic        mode_req,
  input  wire logic [2:0]  mode_sel,
  input  wire logic [13:0] mode_opcode,
  input  wire logic        train_enable,
  input  wire logic        train_range,
  input  wire logic [5:0]  train_level,
  input  wire logic        col_req,
  input  wire logic        col_write,
  input  wire logic [1:0]  col_group,
  input  wire logic [1:0]  col_bank,
  input  wire logic [9:0]  col_addr,
  output logic             ready,
  output logic             mode_done
);

  // Spacing code from the data rate, never a reserved code
  localparam logic [2:0] RATE_SPACE =
    (DATA_RATE <= mode_six_pkg::RATE_4_MAX) ? mode_six_pkg::SPACE_CODE_4 :
    (DATA_RATE <= mode_six_pkg::RATE_5_MAX) ? mode_six_pkg::SPACE_CODE_5 :
    (DATA_RATE <= mode_six_pkg::RATE_6_MAX) ? mode_six_pkg::SPACE_CODE_6 :
    (DATA_RATE <= mode_six_pkg::RATE_7_MAX) ? mode_six_pkg::SPACE_CODE_7 :
                                              mode_six_pkg::SPACE_CODE_8; // [R4] [R15]

  logic [6:0]  last_vref;
  logic        take_mode;
  logic        take_col;
  logic        force_en;
  logic [13:0] sixth_bits;

  assign take_mode = ready && mode_req && (mode_sel != mode_six_pkg::SEL_FORBIDDEN);
  assign take_col  = ready && col_req && !mode_req;
  assign force_en  = {train_range, train_level} != last_vref;

  // Sixth register payload: equalisation zero, enable kept on any level change
  assign sixth_bits = {1'b0, RATE_SPACE, 2'b00, train_enable || force_en,
                       train_range, train_level}; // [R6] [R12]

  // Pin drive: one command cycle, then deselect
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.cs_n  <= 1'b1;
      link.act_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n  <= 1'b1;
      link.bg    <= 2'h0;
      link.ba    <= 2'h0;
      link.a17   <= 1'b0;
      link.a     <= 14'h0000;
    end
    else if (take_mode)
    begin
      link.cs_n  <= 1'b0;
      link.act_n <= 1'b1;
      link.ras_n <= 1'b0; // [R13]
      link.cas_n <= 1'b0;
      link.we_n  <= 1'b0;
      link.bg    <= {1'b0, mode_sel[2]}; // [R1] [R14]
      link.ba    <= mode_sel[1:0];
      link.a17   <= 1'b0; // [R1]
      link.a     <= (mode_sel == mode_six_pkg::SEL_SIXTH) ? sixth_bits : mode_opcode;
    end
    else if (take_col)
    begin
      link.cs_n  <= 1'b0;
      link.act_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b0;
      link.we_n  <= !col_write;
      link.bg    <= col_group;
      link.ba    <= col_bank;
      link.a17   <= 1'b0;
      link.a     <= {4'h0, col_addr};
    end
    else
    begin
      link.cs_n  <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n  <= 1'b1;
    end
  end

  // Handshake: busy for the command cycle, done pulses with a mode write
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ready     <= 1'b1;
      mode_done <= 1'b0;
    end
    else
    begin
      ready     <= !(take_mode || take_col);
      mode_done <= take_mode;
    end
  end

  // Last reference range and level sent, for the enable guard
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_vref <= 7'h00;
    end
    else if (take_mode && (mode_sel == mode_six_pkg::SEL_SIXTH))
    begin
      last_vref <= {train_range, train_level}; // [R12]
    end
  end

endmodule

//--- mode_link_sva.sv
`timescale 1ns/1ns
module mode_link_sva
#(
  parameter int DATA_RATE = 3200
)
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        act_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  bg,
  input wire logic [1:0]  ba,
  input wire logic        a17,
  input wire logic [13:0] a
);
  // Spacing code the data rate calls for
  localparam logic [2:0] SPACE_EXP = (DATA_RATE <= 1333) ? 3'h0 : (DATA_RATE <= 1866) ? 3'h1 :
    (DATA_RATE <= 2400) ? 3'h2 : (DATA_RATE <= 2666) ? 3'h3 : 3'h4;
  logic [6:0] last_ref;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence mode_cmd_s;
    !cs_n && act_n && !ras_n && !cas_n && !we_n;
  endsequence
  sequence sixth_s;
    mode_cmd_s ##0 ({bg[0], ba} == 3'h6);
  endsequence
  // Range and level as last sent to the sixth register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      last_ref <= 7'h00;
    else if (!cs_n && act_n && !ras_n && !cas_n && !we_n && {bg[0], ba} == 3'h6)
      last_ref <= a[6:0];
  end
  rsv_bits_zero_a : assert property (mode_cmd_s |-> !bg[1] && !a17)
    else $error("reserved bit set in mode write");
  select_legal_a : assert property (mode_cmd_s |-> {bg[0], ba} != 3'h7)
    else $error("forbidden select sent");
  spacing_code_a : assert property (sixth_s |-> a[12:10] == SPACE_EXP)
    else $error("spacing code does not suit data rate");
  equalise_zero_a : assert property (sixth_s |-> {a[13], a[9:8]} == 3'h0)
    else $error("equalisation field not zero");
  ref_guard_a : assert property (sixth_s |-> a[7] || a[6:0] == last_ref)
    else $error("reference change without enable");
  cmd_single_a : assert property (!cs_n |=> cs_n)
    else $error("command held over one cycle");
  idle_high_a : assert property (cs_n |-> act_n && ras_n && cas_n && we_n)
    else $error("command pins not high while idle");
  mode_pins_low_a : assert property (!cs_n && act_n && !ras_n |-> !cas_n && !we_n)
    else $error("mode write with a strobe high");
endmodule

//--- ddr4_mode_register_six_tb.sv
`timescale 1ns/1ns
module ddr4_mode_register_six_tb;
  logic        clk, rst_n, mode_req, train_enable, train_range, col_req, col_write, ready, mode_done;
  logic [2:0]  mode_sel;
  logic [13:0] mode_opcode;
  logic [5:0]  train_level;
  logic [1:0]  col_group, col_bank;
  logic [9:0]  col_addr;
  logic [6:0]  mwp [2];
  logic        fp [2], rsv [2], eqe [2], sce [2], lve [2], uge [2], viol [2], ten [2], trg [2];
  logic [2:0]  eq [2], sc [2];
  logic [3:0]  scyc [2];
  logic [5:0]  tlv [2];
  logic [13:0] lvh [2];
  logic [18:0] st [2];
  logic [26:0] exq0 [$], exq1 [$];
  logic [6:0]  last_ref, r;
  int          mismatches, tests_run, viol_seen, seed;
  mode_link link [2] ();
  mode_six_controller_end #(.DATA_RATE(3200)) mode_six_controller_end_inst (.clk(clk), .rst_n(rst_n),
    .link(link[0]), .mode_req(mode_req), .mode_sel(mode_sel), .mode_opcode(mode_opcode),
    .train_enable(train_enable), .train_range(train_range), .train_level(train_level), .col_req(col_req),
    .col_write(col_write), .col_group(col_group), .col_bank(col_bank), .col_addr(col_addr), .ready(ready),
    .mode_done(mode_done));
  for (genvar gi = 0; gi < 2; gi++)
  begin : dev
    mode_six_device_end mode_six_device_end_inst (.clk(clk), .rst_n(rst_n), .link(link[gi]),
      .mode_write_pulse(mwp[gi]), .forbidden_code_pulse(fp[gi]), .reserved_bit_err(rsv[gi]),
      .equalisation_err(eqe[gi]), .spacing_code_err(sce[gi]), .level_code_err(lve[gi]),
      .unguarded_change_err(uge[gi]), .data_receiver_equalisation(eq[gi]), .spacing_code(sc[gi]),
      .spacing_cycles(scyc[gi]), .spacing_violation_pulse(viol[gi]), .training_enable(ten[gi]),
      .training_range(trg[gi]), .training_level(tlv[gi]), .level_hundredths(lvh[gi]));
  end
  mode_link_sva #(.DATA_RATE(3200)) mode_link_sva_inst (.clk(clk), .rst_n(rst_n), .cs_n(link[0].cs_n),
    .act_n(link[0].act_n), .ras_n(link[0].ras_n), .cas_n(link[0].cas_n), .we_n(link[0].we_n),
    .bg(link[0].bg), .ba(link[0].ba), .a17(link[0].a17), .a(link[0].a));
  // Pulses and stored fields that a mode word should leave behind
  function automatic logic [26:0] expect_of(input logic [18:0] s, input logic [21:0] w);
    logic [18:0] n;
    n = s;
    if (w[20:18] == 3'h6)
      n = {w[7:0], w[12:10], w[13], w[9:8], w[21] | w[17], |{w[13], w[9:8]}, w[12:10] > 3'h4,
           w[5:0] > 6'h31, !w[7] && w[6:0] != s[17:11]};
    return {7'h01 << w[20:18], w[20:18] == 3'h7, n};
  endfunction
  function automatic logic [26:0] obs(input int i);
    return {mwp[i], fp[i], ten[i], trg[i], tlv[i], sc[i], eq[i], rsv[i], eqe[i], sce[i], lve[i], uge[i]};
  endfunction
  task automatic check(input logic [26:0] seen, input logic [26:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic note(input int i, input logic [21:0] w);
    logic [26:0] e;
    e = expect_of(st[i], w);
    st[i] = e[18:0];
    if (i == 0)
      exq0.push_back(e);
    else
      exq1.push_back(e);
  endtask
  // One request at the controller, then the pins it puts out
  task automatic ctl(input logic m, input logic [2:0] s, input logic [13:0] op, input logic en,
                     input logic [6:0] rv, input logic [2:0] col);
    logic [21:0] w;
    logic        ok;
    logic        e;
    e = en || rv != last_ref;
    w = {1'b0, s, 4'h0, (s == 3'h6) ? {1'b0, 3'h4, 2'b00, e, rv} : op};
    ok = !m || s != 3'h7;
    if (m && ok)
      note(0, w);
    if (m && s == 3'h6)
      last_ref = rv;
    mode_req <= m;
    mode_sel <= s;
    mode_opcode <= op;
    train_enable <= en;
    {train_range, train_level} <= rv;
    col_req <= !m;
    {col_write, col_group} <= col;
    {col_bank, col_addr} <= 12'($random(seed));
    @(posedge clk);
    mode_req <= 1'b0;
    col_req <= 1'b0;
    @(posedge clk);
    check({link[0].cs_n, link[0].act_n, link[0].ras_n, link[0].cas_n, link[0].we_n},
          !ok ? 5'h1f : m ? 5'h08 : {4'h6, !col[2]});
    check({ready, mode_done}, {!ok, m && ok});
    if (m && ok)
      check({link[0].bg, link[0].ba, link[0].a17, link[0].a}, {w[21:17], w[13:0]});
  endtask
  // Drive the second device's pins for one cycle, then release
  task automatic pin(input logic [4:0] c, input logic [21:0] w);
    {link[1].cs_n, link[1].act_n, link[1].ras_n, link[1].cas_n, link[1].we_n} <= c;
    {link[1].bg, link[1].ba, link[1].a17, link[1].a} <= {w[21:17], w[13:0]};
    @(posedge clk);
    {link[1].cs_n, link[1].act_n, link[1].ras_n, link[1].cas_n, link[1].we_n} <= 5'h1f;
    {link[1].bg, link[1].ba, link[1].a17, link[1].a} <= ~{w[21:17], w[13:0]};
    @(posedge clk);
  endtask
  task automatic dwr(input logic [21:0] w);
    note(1, w);
    pin(5'h08, w);
    @(posedge clk);
    check(scyc[1], st[1][10:8] > 3'h4 ? 4'h8 : 4'(st[1][10:8]) + 4'h4);
    check(lvh[1], (st[1][17] ? 14'h1194 : 14'h1770) + 14'(st[1][16:11]) * 14'h41);
  endtask
  task summarize;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always #5 clk = ~clk;
  // Compare each mode pulse with the oldest noted result
  always @(posedge clk)
  begin
    if (rst_n && (|mwp[0] || fp[0]))
      check(obs(0), exq0.size() ? exq0.pop_front() : 27'h0);
    if (rst_n && (|mwp[1] || fp[1]))
      check(obs(1), exq1.size() ? exq1.pop_front() : 27'h0);
    if (viol[0])
      viol_seen++;
  end
  initial
  begin
    #50000;
    mismatches++;
    summarize;
  end
  initial
  begin
    clk = 0;
    rst_n = 0;
    seed = 26;
    {mode_req, mode_sel, mode_opcode, train_enable, train_range, train_level} = 26'h0;
    {col_req, col_write, col_group, col_bank, col_addr, last_ref} = 23'h0;
    {st[0], st[1]} = 38'h0;
    {link[1].cs_n, link[1].act_n, link[1].ras_n, link[1].cas_n, link[1].we_n} = 5'h1f;
    {link[1].bg, link[1].ba, link[1].a17, link[1].a} = 19'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int s = 0; s < 8; s++)
      ctl(1'b1, 3'(s), 14'($random(seed)), 1'b0, 7'h0, 3'h0);
    for (int k = 0; k < 6; k++)
    begin
      if (!k[0])
        r = {1'($random(seed)), 6'($unsigned($random(seed)) % 50)};
      ctl(1'b1, 3'h6, 14'h0, k == 5, r, 3'h0);
    end
    ctl(1'b0, 3'h0, 14'h0, 1'b0, 7'h0, 3'h5);
    ctl(1'b0, 3'h0, 14'h0, 1'b0, 7'h0, 3'h5);
    ctl(1'b0, 3'h0, 14'h0, 1'b0, 7'h0, 3'h2);
    $display("Controller path test done");
    for (int k = 0; k < 8; k++)
      dwr({1'b0, 3'h6, 4'h0, k[2], k[2:0], k[1:0], 1'b1, k[0], 6'(k * 7)});
    dwr(22'h380080);
    dwr(22'h1a0080);
    dwr(22'h1800b2);
    dwr(22'h180045);
    dwr(22'h1c0000);
    dwr(22'h0c0000);
    for (int d = 3; d < 5; d++)
    begin
      pin(5'h0d, 22'h100000);
      repeat (d - 2) @(posedge clk);
      pin(5'h0d, 22'h100000);
      check(viol[1], d < 4);
    end
    check(viol_seen, 1);
    check(exq0.size() + exq1.size(), 0);
    $display("Device path test done");
    summarize;
  end
endmodule
